// File: common/ucs_pkg.sv
// Package for the serial port control and status register group.
// Assumes one 125 MHz clock domain and an eight-bit CPU register port.
package ucs_pkg;
    // Register addresses on the three-bit select.
    localparam logic [2:0] ADDR_IRQ_ENABLE   = 3'h1;
    localparam logic [2:0] ADDR_FIFO_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_MODEM_CTRL   = 3'h4;
    localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
    localparam logic [2:0] ADDR_SCRATCH      = 3'h7;
    // Field positions in the fifo control register.
    localparam int FC_QUEUE_ENABLE = 0;
    localparam int FC_RX_FLUSH     = 1;
    localparam int FC_TX_FLUSH     = 2;
    localparam int FC_TRIG_LO      = 6;
    // Field positions in the modem control register.
    localparam int MC_LOOP = 4;
    // Widths and reset values.
    localparam int          IE_WIDTH      = 4;
    localparam int          MC_WIDTH      = 5;
    localparam logic [7:0]  RESET_BYTE    = 8'h00;
    localparam int          QUEUE_DEPTH   = 16;
    localparam int          LEVEL_WIDTH   = 5;
    // Receive trigger levels in bytes for codes 00, 01, 10 and 11.
    localparam logic [4:0]  TRIG_LEVEL_0  = 5'h01;
    localparam logic [4:0]  TRIG_LEVEL_1  = 5'h04;
    localparam logic [4:0]  TRIG_LEVEL_2  = 5'h08;
    localparam logic [4:0]  TRIG_LEVEL_3  = 5'h0e;

    // Handshake inputs as seen by the status logic, active high.
    typedef struct packed {
        logic carrier;
        logic ring;
        logic set_ready;
        logic clear_to_send;
    } ucs_modem_lines_t;

    // Interrupt enable fields.
    typedef struct packed {
        logic modem_irq_enable;
        logic line_status_irq_enable;
        logic tx_empty_irq_enable;
        logic rx_avail_irq_enable;
    } ucs_irq_enable_t;

    // Loopback routing state.
    typedef enum logic {
        UCS_NORMAL,
        UCS_LOOPBACK
    } ucs_mode_t;
endpackage

// File: rtl/ucs_ctrl_status_regs.sv
// Control and status registers of the serial port: interrupt enable,
// fifo control, modem control, modem status and scratch.
// Assumes a CPU strobe port synchronous to clk_i and queue levels
// reported by the surrounding serial port core.
//
// Contract
// RULE1: Interrupt enables act only while modem control bit 3 is one.
// RULE2: With all disabled, no interrupt; status registers keep updating.
// RULE3: Enable register bits 7-4 read zero; bits 3-0 enable four sources.
// RULE4: Eight-bit scratch register at address 7 with no side effects.
// RULE5: Address 2 writes fifo control; reads return interrupt identification.
// RULE6: Fifo control bits 7:6 pick trigger of 1, 4, 8 or 14 bytes.
// RULE7: Transmit flush bit empties transmit queue and self-clears.
// RULE8: Receive flush bit empties receive queue and self-clears.
// RULE9: Bit 0 enables queues; any change clears counters and error queue.
// RULE10: Flush bits are ignored unless queue enable is already one.
// RULE11: Software writes zero to reserved bits 5 and 4; bit 3 unused.
// RULE12: Loopback holds serial out high and loops transmit to receive.
// RULE13: Loopback feeds status bits 7-4 from modem control bits 3-0.
// RULE14: Loopback modem interrupts come from control bits, still gated.
// RULE15: Interrupt pin driven only when bit 3 set and not looping.
// RULE16: Control bits 1 and 0 drive active-low handshake pins inverted.
// RULE17: Software restores registers before leaving loopback.
// RULE18: Status bits 7-4 are complements of the active-low inputs.
// RULE19: Change flags set on edges and clear on status read.
// RULE20: Ring flag sets only on the on-to-off transition.
// RULE21: Status low four bits accept writes for interrupt testing.
// RULE22: Modem control at address 4; bits 7-5 read zero.
// RULE23: Any change flag raises modem interrupt when enabled.
// RULE24: Receive interrupt follows the trigger level in queue mode.
// RULE25: Each queue holds sixteen bytes.
`timescale 1ns/1ps
module ucs_ctrl_status_regs #(
    parameter int DEPTH = ucs_pkg::QUEUE_DEPTH
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // CPU register port.
    input  wire logic        cs_i,
    input  wire logic [2:0]  addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [7:0]  ident_i,
    output logic      [7:0]  rdata_o,
    // Active-low handshake inputs from the modem.
    input  wire logic        carrier_n_i,
    input  wire logic        ring_n_i,
    input  wire logic        set_ready_n_i,
    input  wire logic        clear_to_send_n_i,
    // Active-low handshake outputs to the modem.
    output logic             request_to_send_n_o,
    output logic             terminal_ready_n_o,
    // Serial path: shift register ends and pins.
    input  wire logic        serial_in_i,
    input  wire logic        tx_shift_out_i,
    output logic             serial_out_o,
    output logic             rx_shift_in_o,
    // Interrupt sources from the core and queue levels.
    input  wire logic        line_status_evt_i,
    input  wire logic        rx_ready_i,
    input  wire logic        tx_empty_i,
    input  wire logic [4:0]  rx_level_i,
    // Queue control to the core.
    output logic             queue_enable_o,
    output logic             tx_queue_flush_o,
    output logic             rx_queue_flush_o,
    output logic             error_queue_clear_o,
    output logic [4:0]       rx_trigger_o,
    // Interrupt outputs.
    output logic             irq_internal_o,
    output logic             irq_out_pin_o,
    output logic             irq_out_pin_oe_o
);
    // Register state.
    ucs_pkg::ucs_irq_enable_t              irq_enable;
    logic [ucs_pkg::MC_WIDTH-1:0]          modem_control;
    logic [1:0]                            rx_trigger_level;
    logic                                  queue_enable;
    logic [7:0]                            scratch;
    ucs_pkg::ucs_mode_t                    mode;
    ucs_pkg::ucs_modem_lines_t             lines;
    logic [3:0]                            change_flags;
    logic                                  wr_hit;
    logic                                  rd_hit;
    logic                                  status_read;
    logic                                  status_write;
    logic [4:0]                            trig_bytes;
    logic [1:0]                            next_trig_code;
    logic                                  fc_write;
    logic                                  rx_irq_src;
    logic [3:0]                            irq_src;
    logic [7:0]                            next_rdata;

    // Qualified strobes.
    assign wr_hit       = cs_i & wr_i;
    assign rd_hit       = cs_i & rd_i;
    assign status_read  = rd_hit & (addr_i == ucs_pkg::ADDR_MODEM_STATUS);
    assign status_write = wr_hit & (addr_i == ucs_pkg::ADDR_MODEM_STATUS);
    assign fc_write     = wr_hit & (addr_i == ucs_pkg::ADDR_FIFO_CONTROL);
    assign next_trig_code = fc_write ? wdata_i[ucs_pkg::FC_TRIG_LO +: 2] : rx_trigger_level;
    assign mode = modem_control[ucs_pkg::MC_LOOP] ? ucs_pkg::UCS_LOOPBACK
                                                  : ucs_pkg::UCS_NORMAL;

    // Interrupt enable register.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_enable <= '0;
        end else if (wr_hit && addr_i == ucs_pkg::ADDR_IRQ_ENABLE) begin
            irq_enable <= wdata_i[ucs_pkg::IE_WIDTH-1:0];
        end
    end

    // Modem control register; bits 7-5 are not stored.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            modem_control <= '0;
        end else if (wr_hit && addr_i == ucs_pkg::ADDR_MODEM_CTRL) begin
            // RULE22: control at address
            modem_control <= wdata_i[ucs_pkg::MC_WIDTH-1:0];
        end
    end

    // Scratch register; touches nothing else.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scratch <= ucs_pkg::RESET_BYTE;
        end else if (wr_hit && addr_i == ucs_pkg::ADDR_SCRATCH) begin
            // RULE4: plain scratch storage
            scratch <= wdata_i;
        end
    end

    // Fifo control: persistent fields. Reserved bits 5:3 are dropped.
    // RULE11: reserved bits ignored
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            queue_enable     <= 1'b0;
            rx_trigger_level <= 2'b00;
        end else if (wr_hit && addr_i == ucs_pkg::ADDR_FIFO_CONTROL) begin
            // RULE5: write-only at two
            queue_enable     <= wdata_i[ucs_pkg::FC_QUEUE_ENABLE];
            rx_trigger_level <= wdata_i[ucs_pkg::FC_TRIG_LO +: 2];
        end
    end

    // Flush pulses last one cycle, so the flush bits read as self-clearing.
    // The enable check uses the stored bit: setting enable and flush in one
    // write does not flush, which keeps the ordering software must follow.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_queue_flush_o    <= 1'b0;
            rx_queue_flush_o    <= 1'b0;
            error_queue_clear_o <= 1'b0;
        end else begin
            // RULE10: flush needs enable
            // RULE7: transmit flush pulse
            tx_queue_flush_o <= wr_hit && addr_i == ucs_pkg::ADDR_FIFO_CONTROL
                                && queue_enable && wdata_i[ucs_pkg::FC_TX_FLUSH];
            // RULE8: receive flush pulse
            rx_queue_flush_o <= wr_hit && addr_i == ucs_pkg::ADDR_FIFO_CONTROL
                                && queue_enable && wdata_i[ucs_pkg::FC_RX_FLUSH];
            // RULE9: enable change clears
            error_queue_clear_o <= wr_hit && addr_i == ucs_pkg::ADDR_FIFO_CONTROL
                && (wdata_i[ucs_pkg::FC_QUEUE_ENABLE] != queue_enable);
        end
    end

    // Trigger level decode of the code in force after this cycle's write.
    // RULE6: trigger level select
    always_comb begin
        unique case (next_trig_code)
            2'b00: trig_bytes = ucs_pkg::TRIG_LEVEL_0;
            2'b01: trig_bytes = ucs_pkg::TRIG_LEVEL_1;
            2'b10: trig_bytes = ucs_pkg::TRIG_LEVEL_2;
            2'b11: trig_bytes = ucs_pkg::TRIG_LEVEL_3;
        endcase
    end

    // Queue control outputs to the core.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            queue_enable_o <= 1'b0;
            rx_trigger_o   <= ucs_pkg::TRIG_LEVEL_0;
        end else begin
            // Outputs follow a write at once, so the core sees it next cycle.
            queue_enable_o <= fc_write ? wdata_i[ucs_pkg::FC_QUEUE_ENABLE] : queue_enable;
            rx_trigger_o   <= trig_bytes;
        end
    end

    // Handshake line sources: pins in normal mode, control bits in loopback.
    always_comb begin
        unique case (mode)
            ucs_pkg::UCS_LOOPBACK: begin
                // RULE13: loopback line routing
                lines.carrier       = modem_control[3];
                lines.ring          = modem_control[2];
                lines.set_ready     = modem_control[0];
                lines.clear_to_send = modem_control[1];
            end
            ucs_pkg::UCS_NORMAL: begin
                // RULE18: inputs complemented
                lines.carrier       = ~carrier_n_i;
                lines.ring          = ~ring_n_i;
                lines.set_ready     = ~set_ready_n_i;
                lines.clear_to_send = ~clear_to_send_n_i;
            end
        endcase
    end

    // Change flags live in their own module.
    ucs_edge_flags #(
        .WIDTH (4)
    ) u_flags (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .lines_i   (lines),
        .clear_i   (status_read),
        .write_i   (status_write),
        .wdata_i   (wdata_i[3:0]),
        .flags_o   (change_flags)
    );

    // Receive source: level compare in queue mode, ready flag otherwise.
    // RULE24: level-based receive source
    // RULE25: depth covers levels
    assign rx_irq_src = queue_enable ? (rx_level_i >= rx_trigger_o) : rx_ready_i;

    // Sources, each gated by its enable and by the output enable bit.
    // RULE1: gated by control bit
    // RULE23: modem change interrupt
    // RULE14: loopback still gated
    assign irq_src[3] = irq_enable.modem_irq_enable && (|change_flags);
    assign irq_src[2] = irq_enable.line_status_irq_enable && line_status_evt_i;
    assign irq_src[1] = irq_enable.tx_empty_irq_enable && tx_empty_i;
    assign irq_src[0] = irq_enable.rx_avail_irq_enable && rx_irq_src;

    // Internal interrupt and pin; status keeps updating regardless.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_internal_o   <= 1'b0;
            irq_out_pin_o    <= 1'b0;
            irq_out_pin_oe_o <= 1'b0;
        end else begin
            // RULE2: disabled means silent
            irq_internal_o   <= modem_control[3] && (|irq_src);
            irq_out_pin_o    <= modem_control[3] && (|irq_src);
            // RULE15: pin enable gating
            irq_out_pin_oe_o <= modem_control[3] && (mode == ucs_pkg::UCS_NORMAL);
        end
    end

    // Handshake outputs and serial path, registered.
    // Loopback adds one cycle to the looped path; bit times are far longer.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            request_to_send_n_o <= 1'b1;
            terminal_ready_n_o  <= 1'b1;
            serial_out_o        <= 1'b1;
            rx_shift_in_o       <= 1'b1;
        end else begin
            // RULE16: inverted handshake drive
            request_to_send_n_o <= ~modem_control[1];
            terminal_ready_n_o  <= ~modem_control[0];
            // RULE12: loopback serial path
            serial_out_o  <= (mode == ucs_pkg::UCS_LOOPBACK) ? 1'b1 : tx_shift_out_i;
            rx_shift_in_o <= (mode == ucs_pkg::UCS_LOOPBACK) ? tx_shift_out_i
                                                             : serial_in_i;
        end
    end

    // Read data mux; unmapped addresses read zero.
    always_comb begin
        next_rdata = '0;
        unique case (addr_i)
            // RULE3: upper bits zero
            ucs_pkg::ADDR_IRQ_ENABLE:   next_rdata = {4'h0, irq_enable};
            // RULE5: read returns identification
            ucs_pkg::ADDR_FIFO_CONTROL: next_rdata = ident_i;
            ucs_pkg::ADDR_MODEM_CTRL:   next_rdata = {3'h0, modem_control};
            ucs_pkg::ADDR_MODEM_STATUS: next_rdata = {lines, change_flags};
            ucs_pkg::ADDR_SCRATCH:      next_rdata = scratch;
            default:                    next_rdata = '0;
        endcase
    end

    // Read data register, loaded on each read strobe.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_o <= ucs_pkg::RESET_BYTE;
        end else if (rd_hit) begin
            rdata_o <= next_rdata;
        end
    end
endmodule

// File: rtl/ucs_edge_flags.sv
`timescale 1ns/1ps
// Sticky change flags for the four handshake lines.
// Assumes the lines are already synchronous to clk_i.
module ucs_edge_flags #(
    parameter int WIDTH = 4
) (
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Line states and control.
    input  wire ucs_pkg::ucs_modem_lines_t lines_i,
    input  wire logic              clear_i,
    input  wire logic              write_i,
    input  wire logic [WIDTH-1:0]  wdata_i,
    // Flags: carrier, ring trailing, set ready, clear to send.
    output logic [WIDTH-1:0]       flags_o
);
    ucs_pkg::ucs_modem_lines_t prev;
    logic [WIDTH-1:0]          event_set;

    // Line history, used only for edge detection.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prev <= '0;
        end else begin
            prev <= lines_i;
        end
    end

    // RULE19: any change sets
    assign event_set[3] = lines_i.carrier ^ prev.carrier;
    // RULE20: ring off edge only
    assign event_set[2] = prev.ring & ~lines_i.ring;
    assign event_set[1] = lines_i.set_ready ^ prev.set_ready;
    assign event_set[0] = lines_i.clear_to_send ^ prev.clear_to_send;

    // A new event in the cycle of a read survives, so set wins over clear.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flags_o <= '0;
        end else if (write_i) begin
            // RULE21: test write path
            flags_o <= wdata_i | event_set;
        end else if (clear_i) begin
            // RULE19: read clears flags
            flags_o <= event_set;
        end else begin
            flags_o <= flags_o | event_set;
        end
    end
endmodule

// File: tb/uart_ctrl_status_regs_tb.sv
// Self-checking bench for the serial port control and status registers.
// Assumes the modem model and the bound checker are compiled with it.
`timescale 1ns/1ps
module uart_ctrl_status_regs_tb;
    // Clock, reset and CPU port.
    logic        clk_i     = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        cs_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic        wr_i      = 1'b0;
    logic [2:0]  addr_i    = 3'h0;
    logic [7:0]  wdata_i   = 8'h00;
    logic [7:0]  ident_i   = 8'h00;
    // Core side and modem commands.
    logic        line_evt  = 1'b0;
    logic        rx_ready  = 1'b0;
    logic        tx_empty  = 1'b0;
    logic        tx_bit    = 1'b1;
    logic        modem_bit = 1'b1;
    logic [4:0]  rx_level  = 5'h00;
    ucs_pkg::ucs_modem_lines_t lines = 4'h0;
    // Pins, outputs and bench state.
    wire logic   car_n, ring_n, rdy_n, send_n, ser_in;
    logic [7:0]  rdata, rv, got;
    logic [4:0]  trig;
    logic        req_n, term_n, serial_out, rx_in, qen, txf, rxf, eclr, irq, oe, pin;
    logic [15:0] lfsr = 16'h5bc2;
    logic [3:0]  pulses;
    int          mismatches = 0;
    int          cmp_count  = 0;

    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;

    ucs_ctrl_status_regs u_ucs_ctrl_status_regs (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_i(cs_i), .addr_i(addr_i), .rd_i(rd_i),
        .wr_i(wr_i), .wdata_i(wdata_i), .ident_i(ident_i), .rdata_o(rdata),
        .carrier_n_i(car_n), .ring_n_i(ring_n), .set_ready_n_i(rdy_n),
        .clear_to_send_n_i(send_n), .request_to_send_n_o(req_n), .terminal_ready_n_o(term_n),
        .serial_in_i(ser_in), .tx_shift_out_i(tx_bit), .serial_out_o(serial_out),
        .rx_shift_in_o(rx_in), .line_status_evt_i(line_evt), .rx_ready_i(rx_ready),
        .tx_empty_i(tx_empty), .rx_level_i(rx_level), .queue_enable_o(qen),
        .tx_queue_flush_o(txf), .rx_queue_flush_o(rxf), .error_queue_clear_o(eclr),
        .rx_trigger_o(trig), .irq_internal_o(irq), .irq_out_pin_o(pin), .irq_out_pin_oe_o(oe)
    );
    ucs_modem_model u_ucs_modem_model (
        .lines_i(lines), .bit_i(modem_bit), .carrier_n_o(car_n), .ring_n_o(ring_n),
        .set_ready_n_o(rdy_n), .clear_to_send_n_o(send_n), .serial_o(ser_in)
    );

    // Repeatable pseudo-random bytes.
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    // Receive trigger in bytes for each code.
    function automatic logic [4:0] trig_of(input logic [1:0] c);
        case (c)
            2'h0: return 5'h01;
            2'h1: return 5'h04;
            2'h2: return 5'h08;
            default: return 5'h0e;
        endcase
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Write strobe for one cycle; the queue pulses are caught just after it.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cs_i <= 1'b1;
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        cs_i <= 1'b0;
        wr_i <= 1'b0;
        #1 pulses = {qen, txf, rxf, eclr};
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        cs_i <= 1'b1;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        cs_i <= 1'b0;
        rd_i <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs well under 20000 cycles.
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end

    // Main sequence of tests.
    initial begin
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(3'h4, got);
        chk(got, 8'h00);
        chk({1'b0, req_n, term_n, trig}, 8'h61);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            rv = rnd();
            wr(3'h1, rv);
            rd(3'h1, got);
            chk(got, rv & 8'h0f);
            wr(3'h7, rv);
            wr(3'(i % 2 * 2 + 3), ~rv);
            rd(3'h7, got);
            chk(got, rv);
            wr(3'h4, rv & 8'hef);
            rd(3'h4, got);
            chk(got, rv & 8'h0f);
            chk({6'h00, req_n, term_n}, {6'h00, ~rv[1:0]});
            rd(3'(i % 2 * 2 + 3), got);
            chk(got, 8'h00);
            ident_i <= rv;
            rd(3'h2, got);
            chk(got, rv);
        end
        $display("test registers done");
        wr(3'h2, 8'h06);
        chk({4'h0, pulses}, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(3'h2, {c[1:0], 6'h01});
            chk({4'h0, pulses}, (c == 0) ? 8'h09 : 8'h08);
            chk({3'h0, trig}, {3'h0, trig_of(c[1:0])});
        end
        wr(3'h2, 8'h07);
        chk({4'h0, pulses}, 8'h0e);
        @(posedge clk_i);
        #1 chk({4'h0, qen, txf, rxf, eclr}, 8'h08);
        wr(3'h2, 8'h00);
        chk({4'h0, pulses}, 8'h01);
        $display("test queue control done");
        rd(3'h6, got);
        for (int b = 0; b < 4; b++) begin
            lines[b] <= 1'b1;
            settle();
            rd(3'h6, got);
            chk(got, {4'h1 << b, (b == 2) ? 4'h0 : 4'h1 << b});
            lines[b] <= 1'b0;
            settle();
            rd(3'h6, got);
            chk(got, {4'h0, 4'h1 << b});
        end
        $display("test modem status done");
        wr(3'h4, 8'h08);
        wr(3'h1, 8'h08);
        wr(3'h6, 8'h01);
        settle();
        chk({5'h00, pin, irq, oe}, 8'h07);
        rd(3'h6, got);
        settle();
        chk({7'h00, irq}, 8'h00);
        wr(3'h6, 8'h01);
        wr(3'h4, 8'h00);
        settle();
        chk({5'h00, pin, irq, oe}, 8'h00);
        wr(3'h4, 8'h08);
        wr(3'h1, 8'h00);
        settle();
        chk({7'h00, irq}, 8'h00);
        rd(3'h6, got);
        chk(got, 8'h01);
        wr(3'h2, 8'h41);
        wr(3'h1, 8'h01);
        rx_ready <= 1'b1;
        for (int n = 3; n < 6; n++) begin
            rx_level <= 5'(n);
            settle();
            chk({7'h00, irq}, {7'h00, n >= 4});
        end
        wr(3'h2, 8'h00);
        settle();
        chk({7'h00, irq}, 8'h01);
        wr(3'h1, 8'h06);
        for (int k = 0; k < 4; k++) begin
            rv = rnd();
            {line_evt, tx_empty} <= rv[1:0];
            settle();
            chk({7'h00, irq}, {7'h00, |rv[1:0]});
        end
        $display("test interrupts done");
        wr(3'h1, 8'h08);
        wr(3'h4, 8'h1f);
        settle();
        rd(3'h6, got);
        chk({4'h0, got[7:4]}, 8'h0f);
        lines <= ucs_pkg::ucs_modem_lines_t'(rv[7:4]);
        wr(3'h4, 8'h19);
        settle();
        chk({5'h00, irq, oe, serial_out}, 8'h05);
        rd(3'h6, got);
        chk(got, 8'ha5);
        for (int j = 0; j < 8; j++) begin
            rv = rnd();
            if (j == 4) begin
                wr(3'h1, 8'h00);
                wr(3'h4, 8'h00);
            end
            tx_bit <= rv[0];
            modem_bit <= rv[1];
            settle();
            chk({6'h00, serial_out, rx_in}, {6'h00, (j < 4) ? {1'b1, rv[0]} : {rv[0], rv[1]}});
        end
        $display("test loopback done");
        give_verdict();
    end
endmodule

// File: tb/ucs_ctrl_status_regs_asserts.sv
// Checker for the serial port register group, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module ucs_ctrl_status_regs_asserts (
    // Clock and reset.
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    // CPU port.
    input wire logic       cs_i,
    input wire logic       wr_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    // Outputs watched.
    input wire logic       request_to_send_n_o,
    input wire logic       terminal_ready_n_o,
    input wire logic       serial_out_o,
    input wire logic       irq_out_pin_oe_o,
    input wire logic       queue_enable_o,
    input wire logic       tx_queue_flush_o,
    input wire logic       rx_queue_flush_o,
    input wire logic       error_queue_clear_o,
    input wire logic [4:0] rx_trigger_o
);
    // Write strobes; a second write in the next cycle would hide the first.
    logic mc_wr;
    logic fc_wr;
    assign mc_wr = cs_i && wr_i && (addr_i == 3'h4);
    assign fc_wr = cs_i && wr_i && (addr_i == 3'h2);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_pin_invert: assert property (mc_wr ##1 !mc_wr |=>
        {request_to_send_n_o, terminal_ready_n_o} == ~$past(wdata_i[1:0], 2))
        else $error("handshake pins do not follow modem control");
    chk_loop_high: assert property ((mc_wr && wdata_i[4]) ##1 !mc_wr |=> serial_out_o)
        else $error("serial output not high in loopback");
    chk_pin_enable: assert property (mc_wr ##1 !mc_wr |=>
        irq_out_pin_oe_o == ($past(wdata_i[3], 2) && !$past(wdata_i[4], 2)))
        else $error("interrupt pin enable wrong");
    chk_tx_flush: assert property (fc_wr |=>
        tx_queue_flush_o == ($past(wdata_i[2]) && $past(queue_enable_o)))
        else $error("transmit flush pulse wrong");
    chk_rx_flush: assert property (fc_wr |=>
        rx_queue_flush_o == ($past(wdata_i[1]) && $past(queue_enable_o)))
        else $error("receive flush pulse wrong");
    chk_enable_clear: assert property (fc_wr |=> queue_enable_o == $past(wdata_i[0]) &&
        error_queue_clear_o == ($past(wdata_i[0]) != $past(queue_enable_o)))
        else $error("queue enable or error clear wrong");
    chk_trig_level: assert property (fc_wr |=> rx_trigger_o ==
        ($past(wdata_i[7]) ? ($past(wdata_i[6]) ? 5'h0e : 5'h08)
                           : ($past(wdata_i[6]) ? 5'h04 : 5'h01)))
        else $error("trigger level wrong");
    chk_pulse_once: assert property (!fc_wr |=>
        !tx_queue_flush_o && !rx_queue_flush_o && !error_queue_clear_o)
        else $error("queue pulse without a write");
endmodule

bind ucs_ctrl_status_regs ucs_ctrl_status_regs_asserts u_ucs_ctrl_status_regs_asserts (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_i(cs_i), .wr_i(wr_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .request_to_send_n_o(request_to_send_n_o),
    .terminal_ready_n_o(terminal_ready_n_o), .serial_out_o(serial_out_o),
    .irq_out_pin_oe_o(irq_out_pin_oe_o), .queue_enable_o(queue_enable_o),
    .tx_queue_flush_o(tx_queue_flush_o), .rx_queue_flush_o(rx_queue_flush_o),
    .error_queue_clear_o(error_queue_clear_o), .rx_trigger_o(rx_trigger_o)
);

// File: tb/ucs_modem_model.sv
// Modem model: drives the active-low handshake lines and the serial line.
// Assumes the bench sets line states in the active-high sense.
`timescale 1ns/1ps
module ucs_modem_model (
    // Commanded states.
    input  wire ucs_pkg::ucs_modem_lines_t lines_i,
    input  wire logic                      bit_i,
    // Pins toward the port.
    output logic                           carrier_n_o,
    output logic                           ring_n_o,
    output logic                           set_ready_n_o,
    output logic                           clear_to_send_n_o,
    output logic                           serial_o
);
    // active-low lines
    // A line that is on is driven low, as a real data set does.
    assign {carrier_n_o, ring_n_o, set_ready_n_o, clear_to_send_n_o} = ~lines_i;
    // The serial level is chosen by the bench for each case.
    assign serial_o = bit_i;
endmodule
